// *** rtl/srs_ctrl_end.sv ***
// srs_ctrl_end: memory-controller end; makes the link clock, issues
// refresh and bank commands, mirrors the device bank counter and keeps
// the postpone / pull-in bookkeeping.
// assumes the user holds a request until cmd_ready.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - refresh is cs low, ca 0,0,1.
// - scope bit low single bank, high all.
// - device targets banks round robin zero to seven.
// - reset and self refresh exit zero counters.
// - whole array refresh zeroes both counters.
// - controller tracks target, refreshes idle bank only.
// - single bank refresh waits four spacing delays.
// - only refreshed bank blocked; returns idle.
// - after single bank refresh honour spacing delays.
// - all banks idle before whole array refresh.
// - no whole array refresh with open bank.
// - whole array refresh waits three delays.
// - whole array refresh idles banks, then wait.
// - only no-operation during refresh cycle time.
// - at most eight postponed; nine intervals max.
// - eight pulled in give credit, no more.
// - at most sixteen refreshes per two intervals.
// - sixty-four single bank postponed or pulled in.
// - minimum refreshes inside each 32 ms window.
// - eight single bank refreshes equal one whole.
// - postponed count frozen in self refresh.
// - extra refresh after exit before re-entry.
module srs_ctrl_end import srs_pkg::*; #(
   parameter int REFI = REFI_CYC
) (
   // system
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // command request
   input  wire logic                 cmd_valid,
   input  wire srs_cmd_e             cmd_kind,
   input  wire logic [BANK_W-1:0]    cmd_bank,
   output logic                      cmd_ready,
   // refresh bookkeeping
   output logic [BANK_W-1:0]         pb_target,
   output logic signed [4:0]         refresh_debt,
   output logic                      refresh_urgent,
   output logic                      refresh_overdue,
   output logic                      self_refresh,
   output logic                      extra_refresh_due,
   // link
   srs_link_if.ctrl                  link
);

   localparam int REFI_W = $clog2(REFI + 1);

   if (REFI < 1 || LINK_HALF_CYC < 2) begin : g_chk
      $error("srs_ctrl_end: refresh interval or link divider out of range");
   end

   logic [3:0]           div_cnt;
   logic                 ck_q;
   logic                 slot;
   logic                 legal;
   logic                 take;
   logic                 quiet;
   logic                 pull_ok;
   logic                 all_idle;
   logic                 rp_all_done;
   logic                 pb_wrap;
   logic                 credit;
   logic                 tick;
   logic [REFI_W-1:0]    refi_cnt;
   srs_tmr_t             ab_t;
   srs_tmr_t             pb_t;
   srs_tmr_t             rrd_t;
   logic [BANK_W-1:0]    pb_last;
   srs_tmr_t             rp_t [NUM_BANKS];
   logic [NUM_BANKS-1:0] open;
   logic [NUM_BANKS-1:0] rp_done;
   logic [9:0]           next_ca;

   // link clock divider; commands launch as ck falls
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= '0;
         ck_q    <= 1'b0;
      end else if (div_cnt == 4'(LINK_HALF_CYC - 1)) begin
         div_cnt <= '0;
         ck_q    <= !ck_q;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   assign slot      = ck_q && (div_cnt == 4'(LINK_HALF_CYC - 1));
   assign take      = cmd_valid && cmd_ready;
   assign quiet     = (ab_t == '0);
   assign pull_ok   = (refresh_debt > -5'sd8);
   assign all_idle  = (open == '0);
   assign rp_all_done = (rp_done == '1);

   // legality of the pending request
   always_comb begin
      legal = 1'b0;
      unique case (cmd_kind)
         SRS_REF_PB:   legal = quiet && pb_t == '0 && rrd_t == '0
                               && rp_done[pb_target] && !open[pb_target]
                               && pull_ok;
         SRS_REF_AB:   legal = quiet && pb_t == '0 && rp_all_done
                               && all_idle && pull_ok;
         SRS_ACT:      legal = quiet && rrd_t == '0 && !open[cmd_bank]
                               && rp_done[cmd_bank]
                               && !(pb_t != '0 && pb_last == cmd_bank);
         SRS_PRE:      legal = quiet;
         SRS_PRE_ALL:  legal = quiet;
         SRS_RESET:    legal = quiet;
         SRS_SR_ENTER: legal = quiet && pb_t == '0 && all_idle
                               && !extra_refresh_due;
         SRS_SR_EXIT:  legal = 1'b0;
      endcase
      if (self_refresh)
         legal = (cmd_kind == SRS_SR_EXIT);
   end

   assign cmd_ready = slot && legal;

   // command encoding
   always_comb begin
      next_ca = '0;
      unique case (cmd_kind)
         SRS_REF_PB:   next_ca[2:0] = CA_REF;
         SRS_REF_AB:   begin
            next_ca[2:0]       = CA_REF;
            next_ca[SCOPE_BIT] = 1'b1;
         end
         SRS_SR_ENTER: next_ca[2:0] = CA_REF;
         SRS_ACT:      begin
            next_ca[1:0]                  = CA_ACT;
            next_ca[BANK_LSB +: BANK_W]   = cmd_bank;
         end
         SRS_PRE:      begin
            next_ca[3:0]                  = CA_PRE;
            next_ca[BANK_LSB +: BANK_W]   = cmd_bank;
         end
         SRS_PRE_ALL:  begin
            next_ca[3:0]       = CA_PRE;
            next_ca[ALL_BIT]   = 1'b1;
         end
         SRS_RESET:    next_ca = CA_RESET;
         SRS_SR_EXIT:  next_ca = '0;
      endcase
   end

   // link drive; a slot with no command sends no-operation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         link.cs_n <= 1'b1;
         link.ca   <= '0;
      end else if (take) begin
         link.cs_n <= (cmd_kind == SRS_SR_EXIT);
         link.ca   <= next_ca;
      end else if (slot) begin
         link.cs_n <= 1'b1;
         link.ca   <= '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         link.cke <= 1'b1;
      else if (take && cmd_kind == SRS_SR_ENTER)
         link.cke <= 1'b0;
      else if (take && cmd_kind == SRS_SR_EXIT)
         link.cke <= 1'b1;
   end

   assign link.ck = ck_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         self_refresh <= 1'b0;
      else if (take && cmd_kind == SRS_SR_ENTER)
         self_refresh <= 1'b1;
      else if (take && cmd_kind == SRS_SR_EXIT)
         self_refresh <= 1'b0;
   end

   // mirror of the device bank counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         pb_target <= '0;
      else if (take && (cmd_kind == SRS_RESET || cmd_kind == SRS_SR_EXIT))
         pb_target <= '0;
      else if (take && cmd_kind == SRS_REF_AB)
         pb_target <= '0;
      else if (take && cmd_kind == SRS_REF_PB)
         pb_target <= pb_target + 3'h1;
   end

   // spacing timers; exit reuses the whole-array guard as a settle time
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         ab_t <= '0;
      else if (take && (cmd_kind == SRS_REF_AB || cmd_kind == SRS_SR_EXIT))
         ab_t <= RFCAB_CYC;
      else if (ab_t != '0)
         ab_t <= ab_t - 8'h01;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pb_t    <= '0;
         pb_last <= '0;
      end else if (take && cmd_kind == SRS_REF_PB) begin
         pb_t    <= RFCPB_CYC;
         pb_last <= pb_target;
      end else if (pb_t != '0) begin
         pb_t    <= pb_t - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rrd_t <= '0;
      else if (take && (cmd_kind == SRS_ACT || cmd_kind == SRS_REF_PB))
         rrd_t <= RRD_CYC;
      else if (rrd_t != '0)
         rrd_t <= rrd_t - 8'h01;
   end

   // per-bank precharge timer and open-row mirror
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn)
            rp_t[b] <= '0;
         else if (take && (cmd_kind == SRS_PRE_ALL
                  || (cmd_kind == SRS_PRE && cmd_bank == BANK_W'(b))))
            rp_t[b] <= RP_CYC;
         else if (rp_t[b] != '0)
            rp_t[b] <= rp_t[b] - 8'h01;
      end

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn)
            open[b] <= 1'b0;
         else if (take && (cmd_kind == SRS_PRE_ALL || cmd_kind == SRS_RESET
                  || (cmd_kind == SRS_PRE && cmd_bank == BANK_W'(b))))
            open[b] <= 1'b0;
         else if (take && cmd_kind == SRS_ACT && cmd_bank == BANK_W'(b))
            open[b] <= 1'b1;
      end

      assign rp_done[b] = (rp_t[b] == '0);
   end

   // interval ticker; halted in self refresh so the count stays frozen
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         refi_cnt <= '0;
      else if (self_refresh)
         refi_cnt <= refi_cnt;
      else if (refi_cnt == REFI_W'(REFI - 1))
         refi_cnt <= '0;
      else
         refi_cnt <= refi_cnt + REFI_W'(1);
   end

   assign tick    = !self_refresh && (refi_cnt == REFI_W'(REFI - 1));
   assign pb_wrap = take && cmd_kind == SRS_REF_PB && pb_target == 3'h7;
   assign credit  = (take && cmd_kind == SRS_REF_AB) || pb_wrap;

   // owed refreshes: positive postponed, negative pulled in
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refresh_debt    <= '0;
         refresh_overdue <= 1'b0;
      end else begin
         refresh_overdue <= tick && !credit && refresh_debt == 5'sd8;
         if (tick && !credit && refresh_debt < 5'sd8)
            refresh_debt <= refresh_debt + 5'sd1;
         else if (credit && !tick)
            refresh_debt <= refresh_debt - 5'sd1;
      end
   end

   assign refresh_urgent = (refresh_debt >= 5'sd8);

   // one extra refresh owed after each self refresh exit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         extra_refresh_due <= 1'b0;
      else if (take && cmd_kind == SRS_SR_EXIT)
         extra_refresh_due <= 1'b1;
      else if (credit)
         extra_refresh_due <= 1'b0;
   end

endmodule
`default_nettype wire

// *** include/srs_pkg.sv ***
// srs_pkg: constants, command codes and timing counts shared by both
// ends of the refresh scheduling link.
// assumes a 200 MHz system clock at both ends.
package srs_pkg;

   // system clock
   localparam int CLK_PERIOD_PS = 5000;

   // link clock divider: half period in system clock cycles
   localparam int LINK_HALF_CYC = 5;

   // array geometry
   localparam int NUM_BANKS = 8;
   localparam int BANK_W    = 3;
   localparam int CA_W      = 10;

   // timing figures in ns (plain defaults)
   localparam int WHOLE_ARRAY_REFRESH_CYCLE_TIME_NS = 130;
   localparam int SINGLE_BANK_REFRESH_CYCLE_TIME_NS = 60;
   localparam int ROW_PRECHARGE_TIME_NS             = 18;
   localparam int ACTIVATE_TO_ACTIVATE_DELAY_NS     = 10;

   // rolling refresh window at temperature field 011, and refreshes per window
   localparam int       ROLLING_REFRESH_WINDOW_MS = 32;
   localparam logic [2:0] TEMP_FIELD_NOMINAL      = 3'h3;
   localparam int       REFRESHES_PER_WINDOW      = 8192;
   localparam int       AVERAGE_REFRESH_INTERVAL_NS =
      ROLLING_REFRESH_WINDOW_MS * 1000000 / REFRESHES_PER_WINDOW;

   // least times round up, the longest interval rounds down
   localparam logic [7:0] RFCAB_CYC =
      8'((WHOLE_ARRAY_REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] RFCPB_CYC =
      8'((SINGLE_BANK_REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] RP_CYC =
      8'((ROW_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] RRD_CYC =
      8'((ACTIVATE_TO_ACTIVATE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int REFI_CYC = AVERAGE_REFRESH_INTERVAL_NS * 1000 / CLK_PERIOD_PS;

   // postpone / pull-in limits
   localparam int MAX_POSTPONE = 8;
   localparam int MAX_PULLIN   = 8;

   // command/address field positions
   localparam int SCOPE_BIT = 3;
   localparam int ALL_BIT   = 4;
   localparam int BANK_LSB  = 7;

   // command codes, ca0 in bit 0
   localparam logic [2:0] CA_REF   = 3'h4;
   localparam logic [1:0] CA_ACT   = 2'h2;
   localparam logic [3:0] CA_PRE   = 4'hB;
   localparam logic [2:0] CA_READ  = 3'h5;
   localparam logic [2:0] CA_WRITE = 3'h1;
   localparam logic [9:0] CA_RESET = 10'h3F0;

   typedef enum logic [2:0] {
      SRS_REF_PB, SRS_REF_AB, SRS_ACT, SRS_PRE, SRS_PRE_ALL,
      SRS_RESET, SRS_SR_ENTER, SRS_SR_EXIT
   } srs_cmd_e;

   typedef logic [7:0] srs_tmr_t;

endpackage

// *** include/srs_link_if.sv ***
// srs_link_if: command/address link between controller and memory device.
// the controller makes the link clock; the device samples everything.
`timescale 1ns/1ps
`default_nettype none
interface srs_link_if;
   logic        ck;
   logic        cke;
   logic        cs_n;
   logic [9:0]  ca;

   modport ctrl (output ck, output cke, output cs_n, output ca);
   modport dev  (input ck, input cke, input cs_n, input ca);
endinterface
`default_nettype wire

// *** rtl/srs_dev_end.sv ***
// srs_dev_end: memory-device end; decodes refresh, activate, precharge,
// reset and self refresh from the link and keeps the bank counter.
// assumes the link pins come from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module srs_dev_end import srs_pkg::*; (
   // system
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // link
   srs_link_if.dev                   link,
   // state seen by the user
   output logic [BANK_W-1:0]         bank_ptr,
   output logic [NUM_BANKS-1:0]      bank_refreshing,
   output logic [NUM_BANKS-1:0]      bank_open,
   output logic                      refresh_seen,
   output logic                      refresh_all_seen,
   output logic [BANK_W-1:0]         refresh_bank,
   output logic                      self_refresh,
   output logic                      access_blocked
);

   logic [12:0] s1;
   logic [12:0] s2;
   logic        ck_d;
   logic        cke_d;
   logic        edge_r;
   logic        cmd_sel;
   logic [9:0]  ca;
   logic        is_ref;
   logic        is_act;
   logic        is_pre;
   logic        is_rw;
   logic        is_rst;
   logic [BANK_W-1:0] cmd_bank;
   logic        sr_exit;
   srs_tmr_t    busy_t [NUM_BANKS];

   // two-stage sync; only s2 is read by logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 13'h0C00;
         s2 <= 13'h0C00;
      end else begin
         s1 <= {link.ck, link.cke, link.cs_n, link.ca};
         s2 <= s1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ck_d  <= 1'b0;
         cke_d <= 1'b1;
      end else begin
         ck_d  <= s2[12];
         cke_d <= s2[11];
      end
   end

   assign edge_r   = s2[12] && !ck_d;
   assign cmd_sel  = edge_r && !s2[10];
   assign ca       = s2[9:0];
   assign cmd_bank = ca[BANK_LSB +: BANK_W];
   assign is_ref   = cmd_sel && (ca[2:0] == CA_REF);
   assign is_act   = cmd_sel && (ca[1:0] == CA_ACT) && s2[11];
   assign is_pre   = cmd_sel && (ca[3:0] == CA_PRE) && s2[11];
   assign is_rw    = cmd_sel && s2[11] && (ca[2:0] == CA_READ || ca[2:0] == CA_WRITE);
   assign is_rst   = cmd_sel && s2[11] && (ca == CA_RESET);
   assign sr_exit  = s2[11] && !cke_d && self_refresh;

   // self refresh: refresh code with cke low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         self_refresh <= 1'b0;
      else if (is_ref && !s2[11])
         self_refresh <= 1'b1;
      else if (sr_exit)
         self_refresh <= 1'b0;
   end

   // round-robin bank counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         bank_ptr <= '0;
      else if (is_rst || sr_exit)
         bank_ptr <= '0;
      else if (is_ref && s2[11] && ca[SCOPE_BIT])
         bank_ptr <= '0;
      else if (is_ref && s2[11] && !ca[SCOPE_BIT])
         bank_ptr <= bank_ptr + 3'h1;
   end

   // refresh event report
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refresh_seen     <= 1'b0;
         refresh_all_seen <= 1'b0;
         refresh_bank     <= '0;
      end else begin
         refresh_seen     <= is_ref && s2[11];
         refresh_all_seen <= is_ref && s2[11] && ca[SCOPE_BIT];
         if (is_ref && s2[11])
            refresh_bank <= bank_ptr;
      end
   end

   // per-bank busy timer and open-row state
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit_pb;
      logic hit_ab;
      assign hit_pb = is_ref && s2[11] && !ca[SCOPE_BIT] && (bank_ptr == BANK_W'(b));
      assign hit_ab = is_ref && s2[11] && ca[SCOPE_BIT];

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn)
            busy_t[b] <= '0;
         else if (hit_ab)
            busy_t[b] <= RFCAB_CYC;
         else if (hit_pb)
            busy_t[b] <= RFCPB_CYC;
         else if (busy_t[b] != '0)
            busy_t[b] <= busy_t[b] - 8'h01;
      end

      // refresh leaves the bank idle from the moment the refresh command is decoded
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn)
            bank_open[b] <= 1'b0;
         else if (hit_pb || hit_ab || is_rst)
            bank_open[b] <= 1'b0;
         else if (is_pre && (ca[ALL_BIT] || cmd_bank == BANK_W'(b)))
            bank_open[b] <= 1'b0;
         else if (is_act && cmd_bank == BANK_W'(b) && busy_t[b] == '0)
            bank_open[b] <= 1'b1;
      end

      assign bank_refreshing[b] = (busy_t[b] != '0);
   end

   // only the bank under refresh refuses access; others run on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         access_blocked <= 1'b0;
      else
         access_blocked <= (is_rw || is_act) && bank_refreshing[cmd_bank];
   end

endmodule
`default_nettype wire

// *** bench/srs_link_chk.sv ***
// srs_link_chk: assertions on the command link between the two ends.
// assumes it watches the interface that joins controller and device.
`timescale 1ns/1ps
`default_nettype none
module srs_link_chk import srs_pkg::*; (
   // system
   input  wire logic            clk,
   input  wire logic            rstn,
   // link
   input  wire logic            ck,
   input  wire logic            cke,
   input  wire logic            cs_n,
   input  wire logic [CA_W-1:0] ca
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic                 ck_q;
   logic                 cke_q;
   logic                 extra;
   logic [BANK_W-1:0]    ptr;
   logic [NUM_BANKS-1:0] open_b;
   logic                 launch;
   logic                 is_ref;
   logic                 is_ab;
   logic                 is_pb;
   logic                 is_act;
   // a command starts where ck falls with the chip selected
   assign launch = ck_q && !ck && !cs_n;
   assign is_ref = launch && ca[2:0] == CA_REF;
   assign is_ab  = is_ref && cke && ca[SCOPE_BIT];
   assign is_pb  = is_ref && cke && !ca[SCOPE_BIT];
   assign is_act = launch && ca[1:0] == CA_ACT;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ck_q  <= 1'b0;
         cke_q <= 1'b1;
      end else begin
         ck_q  <= ck;
         cke_q <= cke;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr <= '0;
      end else if (is_ab || (launch && ca == CA_RESET) || (cke && !cke_q)) begin
         ptr <= '0;
      end else if (is_pb) begin
         ptr <= ptr + 3'h1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         open_b <= '0;
      end else if (launch && ca == CA_RESET) begin
         open_b <= '0;
      end else if (is_act) begin
         open_b[ca[BANK_LSB+:BANK_W]] <= 1'b1;
      end else if (launch && ca[3:0] == CA_PRE) begin
         if (ca[ALL_BIT]) open_b <= '0;
         else open_b[ca[BANK_LSB+:BANK_W]] <= 1'b0;
      end
   end
   // one lost internal refresh per exit, repaid by a whole refresh or the eighth single bank refresh
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) extra <= 1'b0;
      else if (cke && !cke_q) extra <= 1'b1;
      else if (is_ab || (is_pb && ptr == 3'h7)) extra <= 1'b0;
   end
   property p_ca_hold;
      ($changed(ca) || $changed(cs_n)) |-> !ck && $past(ck);
   endproperty
   a_ca_hold: assert property (p_ca_hold) else $error("link command moved off a ck fall");
   property p_ck_div;
      $rose(ck) |-> ck[*5] ##1 !ck;
   endproperty
   a_ck_div: assert property (p_ck_div) else $error("link clock high time wrong");
   property p_ab_nop;
      is_ab |-> ##10 cs_n[*8] ##1 cs_n[*8];
   endproperty
   a_ab_nop: assert property (p_ab_nop) else $error("command inside whole refresh cycle");
   property p_pb_space;
      is_pb |-> ##10 !(is_ref || (is_act && ca[BANK_LSB+:BANK_W] == $past(ptr, 10)));
   endproperty
   a_pb_space: assert property (p_pb_space) else $error("single bank refresh spacing");
   property p_ab_idle;
      is_ab |-> open_b == '0;
   endproperty
   a_ab_idle: assert property (p_ab_idle) else $error("whole refresh with bank open");
   property p_pb_idle;
      is_pb |-> !open_b[ptr];
   endproperty
   a_pb_idle: assert property (p_pb_idle) else $error("single refresh to open bank");
   property p_sr_extra;
      $fell(cke) |-> !extra;
   endproperty
   a_sr_extra: assert property (p_sr_extra) else $error("self refresh re-entered too soon");
   property p_act_closed;
      is_act |-> !open_b[ca[BANK_LSB+:BANK_W]];
   endproperty
   a_act_closed: assert property (p_act_closed) else $error("activate to open bank");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// tb_top: both ends joined over the link; random refresh and bank traffic.
// assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top import srs_pkg::*;;
   localparam int REFI = 40;
   logic clk = 0, rstn = 0, cmd_valid = 0, cmd_ready, urgent, overdue;
   logic c_sr, d_sr, extra_due, seen, seen_ab, blocked, took;
   srs_cmd_e cmd_kind = SRS_RESET;
   logic [BANK_W-1:0] cmd_bank = '0, pb_target, bank_ptr, refresh_bank, exp_ptr, prev, bnk;
   logic signed [4:0] refresh_debt, debt0;
   logic [NUM_BANKS-1:0] refreshing, bank_open, exp_open;
   int err_total = 0, total_checks = 0, ref_cnt = 0, exp_ref = 0, n;
   int ab_cnt = 0, exp_ab = 0, od_cnt = 0, blk_cnt = 0;
   integer seed = 32'hd7f2;
   always #2.5 clk = ~clk;
   srs_link_if link ();
   srs_ctrl_end #(.REFI(REFI)) srs_ctrl_end_inst (.clk(clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .cmd_ready(cmd_ready),
      .pb_target(pb_target), .refresh_debt(refresh_debt), .refresh_urgent(urgent),
      .refresh_overdue(overdue), .self_refresh(c_sr), .extra_refresh_due(extra_due), .link(link));
   srs_dev_end srs_dev_end_inst (.clk(clk), .rstn(rstn), .link(link), .bank_ptr(bank_ptr),
      .bank_refreshing(refreshing), .bank_open(bank_open), .refresh_seen(seen),
      .refresh_all_seen(seen_ab), .refresh_bank(refresh_bank), .self_refresh(d_sr),
      .access_blocked(blocked));
   srs_link_chk srs_link_chk_inst (.clk(clk), .rstn(rstn), .ck(link.ck), .cke(link.cke),
      .cs_n(link.cs_n), .ca(link.ca));
   // pulse counters for the one-clock device and controller reports
   always @(posedge clk) begin
      if (seen === 1'b1) ref_cnt <= ref_cnt + 1;
      if (seen_ab === 1'b1) ab_cnt <= ab_cnt + 1;
      if (overdue === 1'b1) od_cnt <= od_cnt + 1;
      if (blocked === 1'b1) blk_cnt <= blk_cnt + 1;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // request held until taken; a refused one gives up after lim clocks
   task automatic issue(input srs_cmd_e k, input logic [2:0] b, input int lim);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_bank <= b;
      took = 1'b0;
      for (int i = 0; i < lim && !took; i++) begin
         @(negedge clk);
         took = (cmd_ready === 1'b1);
         @(posedge clk);
      end
      cmd_valid <= 1'b0;
   endtask
   task automatic go(input srs_cmd_e k, input logic [2:0] b);
      issue(k, b, 400);
      // look after the launching edge has settled
      @(negedge clk);
      check(took, 1, "request taken");
      if (!took) conclude();
      prev = exp_ptr;
      case (k)
         SRS_REF_PB: begin exp_ref++; exp_ptr++; end
         SRS_REF_AB: begin exp_ref++; exp_ab++; exp_ptr = '0; end
         SRS_ACT: exp_open[b] = 1'b1;
         SRS_PRE: exp_open[b] = 1'b0;
         SRS_PRE_ALL: exp_open = '0;
         SRS_SR_ENTER: ;
         default: begin exp_ptr = '0; exp_open = '0; end
      endcase
      for (n = 0; n < 40 && !(ref_cnt == exp_ref && bank_ptr === exp_ptr &&
           bank_open === exp_open && d_sr === c_sr); n++) @(negedge clk);
      check(n < 40, 1, "device settled");
      if (n >= 40) conclude();
      check(8'(ref_cnt), 8'(exp_ref), "refreshes seen");
      check(8'(ab_cnt), 8'(exp_ab), "whole refreshes seen");
      check(bank_ptr, exp_ptr, "device bank counter");
      check(pb_target, exp_ptr, "controller mirror");
      check(bank_open, exp_open, "open banks");
      check(d_sr, c_sr, "self refresh state");
      check(refresh_debt >= -8 && refresh_debt <= 8, 1, "debt range");
      if (k == SRS_REF_PB) check(refresh_bank, prev, "refreshed bank");
      if (k == SRS_REF_PB) check(refreshing, 8'h1 << prev, "bank under refresh");
      if (k == SRS_REF_AB) check(refreshing, 8'hFF, "all banks refreshing");
      @(posedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      exp_ptr = '0;
      exp_open = '0;
      @(posedge clk);
      check(pb_target, 0, "mirror after reset");
      check(bank_ptr, 0, "counter after reset");
      // no refresh for many intervals: postponement saturates
      repeat (12 * REFI) @(posedge clk);
      check(8'(refresh_debt), 8'h08, "debt saturated");
      check(urgent, 1, "refresh urgent");
      go(SRS_REF_AB, 0);
      check(8'(od_cnt), 8'(12 - MAX_POSTPONE), "overdue pulses");
      $display("test postpone done");
      for (int i = 0; i < 60; i++) begin
         bnk = 3'($random(seed));
         case ($unsigned($random(seed)) % 5)
            0: go(SRS_RESET, 0);
            1: begin
               if (exp_open != 0) go(SRS_PRE_ALL, 0);
               go(SRS_REF_AB, 0);
            end
            2: go(exp_open[bnk] ? SRS_PRE : SRS_ACT, bnk);
            default: begin
               if (exp_open[exp_ptr]) go(SRS_PRE, exp_ptr);
               go(SRS_REF_PB, 0);
            end
         endcase
      end
      $display("test random traffic done");
      if (exp_open != 0) go(SRS_PRE_ALL, 0);
      go(SRS_SR_ENTER, 0);
      check(c_sr, 1, "in self refresh");
      debt0 = refresh_debt;
      repeat (3 * REFI) @(posedge clk);
      check(8'(refresh_debt), 8'(debt0), "debt frozen");
      go(SRS_SR_EXIT, 0);
      check(extra_due, 1, "extra refresh owed");
      issue(SRS_SR_ENTER, 0, 100);
      check(took, 0, "re-entry refused");
      @(posedge clk);
      go(SRS_REF_AB, 0);
      check(extra_due, 0, "extra refresh paid");
      go(SRS_SR_ENTER, 0);
      check(8'(blk_cnt), 8'h00, "no blocked access");
      $display("test self refresh done");
      conclude();
   end
endmodule
`default_nettype wire
